// ==== rtl/ert_read_path.sv ====
// two-wire serial eeprom slave, read path with address counter and id page
`timescale 1ns/1ps
module ert_read_path
  import ert_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         scl,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  input  wire logic         chip_select_bit_zero,
  input  wire logic         chip_select_bit_one,
  input  wire logic         chip_select_bit_two,
  input  wire logic         id_locked,
  output logic              mem_rd,
  output ert_mem_req_s      mem_req,
  input  wire logic [7:0]   mem_rdata,
  output logic              standby
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // next counter value; the id page wraps inside itself
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                  input logic id);
    logic [ID_OFS_W-1:0] ofs;
    ofs = a[ID_OFS_W-1:0] + 7'h01;
    if (id) begin
      next_addr = {a[ADDR_W-1:ID_OFS_W], ofs};
    end else begin
      next_addr = a + 16'h0001;
    end
  endfunction : next_addr

  // address put on the memory port
  function automatic logic [ADDR_W-1:0] eff_addr(input logic [ADDR_W-1:0] a,
                                                 input logic id);
    if (id) begin
      eff_addr = {9'h000, a[ID_OFS_W-1:0]};
    end else begin
      eff_addr = a;
    end
  endfunction : eff_addr

  // ----------------------------------------------------------------------
  // system clock side declarations
  // ----------------------------------------------------------------------
  logic              scl_m, scl_s;       // scl synchroniser
  logic              sda_m, sda_s, sda_p; // sda synchroniser and history
  logic              start_det;          // start seen on the bus
  logic              stop_det;           // stop seen on the bus
  ert_phase_e        phase;              // frame opening tracker
  logic              in_start;           // level handed to the link side
  logic              ev_m, ev_s, ev_p;   // event toggle crossing
  logic              tk_m, tk_s, tk_p;   // byte-taken toggle crossing
  logic              ev_pulse;           // one event per toggle change
  logic              tk_pulse;           // one take per toggle change
  logic              drv_m, drv_s;       // drive request crossing
  logic [ADDR_W-1:0] addr;               // internal address counter
  logic              id_mode;            // counter refers to the id page
  logic              fetch_req;          // fetch at the settled counter
  logic              rd_pend;            // memory answer due this cycle
  logic [7:0]        tx_byte;            // byte ready for the link side

  // ----------------------------------------------------------------------
  // link clock side declarations
  // ----------------------------------------------------------------------
  logic              lst_m, lst_s;       // in_start crossing, new frame level
  logic [2:0]        cs_m, cs_s;         // select pin synchroniser
  logic              lock_m, lock_s;     // lock level synchroniser
  ert_state_e        st;                 // byte engine state
  ert_state_e        st_after;           // state taken after the ack slot
  logic [3:0]        cnt;                // bit position, 8 is the ack slot
  logic [7:0]        sr;                 // receive shift register
  logic              ack_pend;           // drive ack in the coming slot
  logic              is_id;              // frame addresses the id page
  logic              a10;                // lock selector from high address
  logic              ev_tgl;             // event toggle, posedge side
  ert_ev_s           ev;                 // event word
  logic              tk_tgl;             // byte-taken toggle, negedge side
  logic [7:0]        txsr;               // transmit shift register
  logic              drv;                // pull sda low request
  logic [7:0]        byte_in;            // byte completed at bit eight
  logic              bit_prev;           // sda at the previous rising scl

  assign byte_in = {sr[6:0], sda_in};

  // ----------------------------------------------------------------------
  // pin synchronisers and bus conditions
  // ----------------------------------------------------------------------
  // two flops per pin; sda_p only watches the second stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_m <= scl;
      scl_s <= scl_m;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  assign start_det = scl_s & sda_p & ~sda_s;
  assign stop_det  = scl_s & ~sda_p & sda_s;
  assign in_start  = (phase == PH_START);

  // frame opening: link toggles are rezeroed during it, so events are muted
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase <= PH_START;  // stays here until scl first falls
    end else if (start_det) begin
      phase <= PH_START;
    end else begin
      unique case (phase)
        PH_START:  if (!scl_s) phase <= PH_LOW;
        PH_LOW:    if (scl_s) phase <= PH_HIGH;
        PH_HIGH:   if (!scl_s) phase <= PH_REARM;
        PH_REARM:  if (scl_s) phase <= PH_SETTLE;  // engine restarts on this rise
        PH_SETTLE: phase <= PH_RUN;
        PH_RUN:    phase <= PH_RUN;
        default:   phase <= PH_START;  // unused codes
      endcase
    end
  end

  // standby: left on start, entered on stop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      standby <= 1'b1;
    end else if (stop_det) begin
      standby <= 1'b1;
    end else if (start_det) begin
      standby <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // crossings from the link side
  // ----------------------------------------------------------------------
  // while a frame opens the history copies follow the toggles silently
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ev_m  <= 1'b0;
      ev_s  <= 1'b0;
      ev_p  <= 1'b0;
      tk_m  <= 1'b0;
      tk_s  <= 1'b0;
      tk_p  <= 1'b0;
      drv_m <= 1'b0;
      drv_s <= 1'b0;
    end else begin
      ev_m  <= ev_tgl;
      ev_s  <= ev_m;
      ev_p  <= ev_s;
      tk_m  <= tk_tgl;
      tk_s  <= tk_m;
      tk_p  <= tk_s;
      drv_m <= drv;
      drv_s <= drv_m;
    end
  end

  assign ev_pulse = (phase == PH_RUN) && (ev_s != ev_p);
  assign tk_pulse = (phase == PH_RUN) && (tk_s != tk_p);

  // open drain pin; only the enable moves, muted while a frame opens
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      sda_oe  <= drv_s && (phase == PH_RUN);
      sda_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // address counter and memory fetch
  // ----------------------------------------------------------------------
  // the counter moves when a byte is handed out, so it is last plus one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr      <= ADDR_RST;
      id_mode   <= 1'b0;
      fetch_req <= 1'b0;
    end else begin
      fetch_req <= 1'b0;
      if (tk_pulse) begin
        addr      <= next_addr(addr, id_mode);
        fetch_req <= 1'b1;
      end else if (ev_pulse) begin
        unique case (ev.kind)
          EV_SEL: begin
            id_mode   <= ev.id;
            fetch_req <= 1'b1;
          end
          EV_HI: addr[15:8] <= ev.data;
          EV_LO: begin
            addr[7:0] <= ev.data;
            id_mode   <= ev.id;
            fetch_req <= 1'b1;
          end
          default: fetch_req <= 1'b0;  // unused code
        endcase
      end
    end
  end

  // one cycle memory: request, then capture the answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_rd  <= 1'b0;
      mem_req <= '0;
      rd_pend <= 1'b0;
      tx_byte <= BYTE_RST;
    end else begin
      mem_rd  <= fetch_req;
      rd_pend <= mem_rd;
      if (fetch_req) begin
        mem_req <= '{id: id_mode, addr: eff_addr(addr, id_mode)};
      end
      if (rd_pend) begin
        tx_byte <= mem_rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // link side synchronisers
  // ----------------------------------------------------------------------
  // frame start level: caught on the fall after start, seen at the second rise
  always_ff @(negedge scl) begin
    lst_m <= in_start;
  end

  // select pins and lock level are slow, two flops each
  always_ff @(posedge scl) begin
    lst_s  <= lst_m;
    cs_m   <= {chip_select_bit_two, chip_select_bit_one, chip_select_bit_zero};
    cs_s   <= cs_m;
    lock_m <= id_locked;
    lock_s <= lock_m;
  end

  // keeps address bit 7, which passes before the start level arrives
  always_ff @(posedge scl) begin
    bit_prev <= sda_in;
  end

  // ----------------------------------------------------------------------
  // receive side, rising scl
  // ----------------------------------------------------------------------
  // a start restarts the byte engine one rise late; bit 7 comes from bit_prev
  always_ff @(posedge scl) begin
    if (lst_s) begin
      sr       <= {6'h00, bit_prev, sda_in};
      cnt      <= CNT_RESUME;
      st       <= ST_DEV;
      st_after <= ST_IDLE;
      ack_pend <= 1'b0;
      is_id    <= 1'b0;
      a10      <= 1'b0;
      ev_tgl   <= 1'b0;
      ev       <= '{kind: EV_SEL, id: 1'b0, data: 8'h00};
    end else if (cnt < LAST_BIT) begin
      sr  <= byte_in;
      cnt <= cnt + 4'h1;
    end else if (cnt == LAST_BIT) begin
      sr  <= byte_in;
      cnt <= ACK_SLOT;
      unique case (st)
        ST_DEV: begin
          // type code, select pins, then direction
          if ((byte_in[7:4] == TYPE_ARRAY || byte_in[7:4] == TYPE_IDPAGE)
              && byte_in[3:1] == cs_s) begin
            ack_pend <= 1'b1;
            is_id    <= (byte_in[7:4] == TYPE_IDPAGE);
            if (byte_in[0]) begin
              st_after <= ST_READ;
              ev       <= '{kind: EV_SEL, id: (byte_in[7:4] == TYPE_IDPAGE), data: 8'h00};
              ev_tgl   <= ~ev_tgl;
            end else begin
              st_after <= ST_AHI;
            end
          end else begin
            ack_pend <= 1'b0;
            st_after <= ST_IDLE;
          end
        end
        ST_AHI: begin
          ack_pend <= 1'b1;
          a10      <= byte_in[LOCK_SEL_BIT];
          st_after <= ST_ALO;
          ev       <= '{kind: EV_HI, id: is_id, data: byte_in};
          ev_tgl   <= ~ev_tgl;
        end
        ST_ALO: begin
          ack_pend <= 1'b1;
          st_after <= ST_WDATA;
          ev       <= '{kind: EV_LO, id: is_id, data: byte_in};
          ev_tgl   <= ~ev_tgl;
        end
        ST_WDATA: begin
          // only the lock query is answered; array writes live elsewhere
          ack_pend <= is_id && a10 && !lock_s;
          st_after <= ST_WDATA;
        end
        ST_READ: begin
          ack_pend <= 1'b0;
          st_after <= ST_READ;
        end
        ST_IDLE: begin
          ack_pend <= 1'b0;
          st_after <= ST_IDLE;
        end
        default: begin
          ack_pend <= 1'b0;  // unused codes
          st_after <= ST_IDLE;
        end
      endcase
    end else begin
      // ack slot: master ack keeps reading, nack or refused byte goes idle
      cnt      <= CNT_FIRST;
      ack_pend <= 1'b0;
      if (st == ST_READ) begin
        st <= sda_in ? ST_IDLE : ST_READ;
      end else begin
        st <= ack_pend ? st_after : ST_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // transmit side, falling scl
  // ----------------------------------------------------------------------
  // bits change while scl is low; in a read the ninth clock is left to the master, otherwise it carries the ack
  always_ff @(negedge scl) begin
    if (lst_s) begin
      tk_tgl <= 1'b0;  // rezeroed while the system side is muted
      drv    <= 1'b0;
    end else if (st == ST_READ) begin
      if (cnt == CNT_FIRST) begin
        txsr   <= {tx_byte[6:0], 1'b0};
        drv    <= ~tx_byte[7];
        tk_tgl <= ~tk_tgl;
      end else if (cnt <= LAST_BIT) begin
        txsr <= {txsr[6:0], 1'b0};
        drv  <= ~txsr[7];
      end else begin
        drv <= 1'b0;
      end
    end else begin
      drv <= (cnt == ACK_SLOT) && ack_pend;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  addr_wrap_a: assert property (@(posedge clk) disable iff (sys_rst)
    tk_pulse && !id_mode && addr == 16'hFFFF |=> addr == 16'h0000)
    else $error("counter did not wrap to zero");

  addr_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    tk_pulse && !id_mode |=> addr == $past(addr) + 16'h0001)
    else $error("counter did not step by one");

  id_offset_a: assert property (@(posedge clk) disable iff (sys_rst)
    mem_rd && mem_req.id |-> mem_req.addr[15:7] == 9'h000)
    else $error("id page fetch used upper address bits");

  fetch_data_a: assert property (@(posedge clk) disable iff (sys_rst)
    mem_rd |=> ##1 tx_byte == $past(mem_rdata))
    else $error("fetched byte not captured");

  addr_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    ev_pulse && ev.kind == EV_LO |=> addr[7:0] == $past(ev.data) ##1 mem_rd)
    else $error("byte address not loaded and fetched");

  stop_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    stop_det && !start_det |=> standby)
    else $error("stop did not return to standby");

  start_mute_a: assert property (@(posedge clk) disable iff (sys_rst)
    start_det |=> !standby && in_start ##1 !sda_oe)
    else $error("start did not reset the interface");

  nack_free_a: assert property (@(posedge scl) disable iff (lst_s)
    st == ST_READ && cnt == ACK_SLOT |-> !drv)
    else $error("data line held in the master ack slot");

  ack_slot_a: assert property (@(posedge scl) disable iff (lst_s)
    st != ST_READ && cnt == ACK_SLOT && ack_pend |-> drv)
    else $error("received byte not acknowledged");

  lock_ack_a: assert property (@(posedge scl) disable iff (lst_s)
    st == ST_WDATA && cnt == LAST_BIT && is_id && a10 |=> ack_pend == !$past(lock_s))
    else $error("lock query answered wrongly");

  dev_match_a: assert property (@(posedge scl) disable iff (lst_s)
    st == ST_DEV && cnt == LAST_BIT && byte_in[7:5] != 3'b101 |=> !ack_pend)
    else $error("foreign address acknowledged");

  wrap_seen_c: cover property (@(posedge clk) disable iff (sys_rst)
    tk_pulse && !id_mode && addr == 16'hFFFF);

  seq_read_c: cover property (@(posedge clk) disable iff (sys_rst)
    tk_pulse ##[1:400] tk_pulse);

  id_read_c: cover property (@(posedge clk) disable iff (sys_rst)
    mem_rd && mem_req.id);

  lock_nack_c: cover property (@(posedge scl) disable iff (lst_s)
    st == ST_WDATA && cnt == LAST_BIT && is_id && a10 && lock_s);

endmodule : ert_read_path

// ==== rtl/ert_pkg.sv ====
// constants and types shared by the two-wire eeprom read path
package ert_pkg;

  // ----------------------------------------------------------------------
  // address and byte layout
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W       = 16;      // array address counter width
  localparam int unsigned ID_OFS_W     = 7;       // offset width inside the id page
  localparam int unsigned LOCK_SEL_BIT = 2;       // a10 as seen in the high address byte
  localparam logic [3:0]  TYPE_ARRAY   = 4'hA;    // device type code of the array
  localparam logic [3:0]  TYPE_IDPAGE  = 4'hB;    // device type code of the id page

  // ----------------------------------------------------------------------
  // bit counter positions
  // ----------------------------------------------------------------------
  localparam logic [3:0]  CNT_FIRST    = 4'h0;    // first bit of a byte
  localparam logic [3:0]  CNT_RESUME   = 4'h2;    // count after the two bits held at restart
  localparam logic [3:0]  LAST_BIT     = 4'h7;    // eighth bit of a byte
  localparam logic [3:0]  ACK_SLOT     = 4'h8;    // ninth clock, acknowledge slot

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;  // counter after reset
  localparam logic [7:0]        BYTE_RST = 8'hFF;     // fetched byte after reset

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  // link side byte engine states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DEV   = 3'b001,
    ST_AHI   = 3'b010,
    ST_ALO   = 3'b011,
    ST_WDATA = 3'b100,
    ST_READ  = 3'b101
  } ert_state_e;

  // system side view of a frame opening
  typedef enum logic [2:0] {
    PH_RUN    = 3'b000,
    PH_START  = 3'b001,
    PH_LOW    = 3'b010,
    PH_HIGH   = 3'b011,
    PH_SETTLE = 3'b100,
    PH_REARM  = 3'b101
  } ert_phase_e;

  // events carried from the link side to the counter
  typedef enum logic [1:0] {
    EV_SEL = 2'b00,
    EV_HI  = 2'b01,
    EV_LO  = 2'b10
  } ert_ev_e;

  // memory read request
  typedef struct packed {
    logic              id;
    logic [ADDR_W-1:0] addr;
  } ert_mem_req_s;

  // link side event word, held stable while its toggle crosses
  typedef struct packed {
    ert_ev_e    kind;
    logic       id;
    logic [7:0] data;
  } ert_ev_s;

endpackage : ert_pkg

// ==== verification/ert_bus_master.sv ====
// behavioural two-wire bus master that faces the read path
`timescale 1ns/1ps
module ert_bus_master
(
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_in
);

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  // quarter of a bit period; 680 ns period keeps scl low well above 200 ns
  localparam int QT = 170;

  // bus idles with the clock standing still and the data line released
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // ----------------------------------------------------------------------
  // bus conditions
  // ----------------------------------------------------------------------
  // start or repeated start; the slave treats any start as a reset
  task automatic start();
    sda_drv = 1'b1;
    #(QT);
    scl = 1'b1;
    #(2*QT);
    sda_drv = 1'b0;
    #(2*QT);
    scl = 1'b0;
    #(QT);
  endtask : start

  // stop: data rises while the clock is high
  task automatic stop();
    sda_drv = 1'b0;
    #(QT);
    scl = 1'b1;
    #(2*QT);
    sda_drv = 1'b1;
    #(2*QT);
  endtask : stop

  // one clock; data changes only while scl is low, line sampled at the rise
  task automatic clock_bit(input logic b, output logic r);
    sda_drv = b;
    #(QT);
    scl = 1'b1;
    r = sda_in;
    #(2*QT);
    scl = 1'b0;
    #(QT);
  endtask : clock_bit

  // ----------------------------------------------------------------------
  // byte transfers, msb first
  // ----------------------------------------------------------------------
  // send a byte, then release the line for the slave's acknowledge
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(d[i], r);
    end
    clock_bit(1'b1, r);
    ack = ~r;
  endtask : write_byte

  // receive a byte; the last wanted byte is left unacknowledged
  task automatic read_byte(input logic ack, output logic [7:0] d, output logic line);
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, d[i]);
    end
    clock_bit(~ack, line);
  endtask : read_byte

endmodule : ert_bus_master

// ==== verification/eeprom_two_wire_read_path_tb.sv ====
// self-checking bench for the two-wire eeprom read path
`timescale 1ns/1ps
module eeprom_two_wire_read_path_tb;
  import ert_pkg::*;

  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic         clk;           // system clock, 20 MHz
  logic         sys_rst;       // synchronous reset
  logic         id_locked;     // id page lock status
  logic [2:0]   sel;           // strap pins {two, one, zero}
  wire logic    scl;           // link clock from the master
  wire logic    m_sda;         // master drive, 1 = released
  wire logic    sda_w;         // resolved data wire
  logic         sda_out;
  logic         sda_oe;
  logic         mem_rd;
  ert_mem_req_s mem_req;
  logic [7:0]   mem_rdata;
  logic         standby;
  int           num_errors;
  int           total_checks;

  // pull-up wins wherever nobody pulls low
  assign sda_w = m_sda & (sda_oe ? sda_out : 1'b1);

  ert_read_path dut (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .scl                  (scl),
    .sda_in               (sda_w),
    .sda_out              (sda_out),
    .sda_oe               (sda_oe),
    .chip_select_bit_zero (sel[0]),
    .chip_select_bit_one  (sel[1]),
    .chip_select_bit_two  (sel[2]),
    .id_locked            (id_locked),
    .mem_rd               (mem_rd),
    .mem_req              (mem_req),
    .mem_rdata            (mem_rdata),
    .standby              (standby)
  );

  ert_bus_master m (
    .scl     (scl),
    .sda_drv (m_sda),
    .sda_in  (sda_w)
  );

  // ----------------------------------------------------------------------
  // clock and memory model
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #(25) clk = ~clk;
  end

  // content pattern; id page content depends on the low seven bits only
  function automatic logic [7:0] pat(input logic id, input logic [15:0] a);
    return id ? ({1'b0, a[6:0]} ^ 8'hC3) : (a[7:0] + a[15:8] + 8'h11);
  endfunction : pat

  // answer is stable from the cycle after the request since mem_req is held
  assign mem_rdata = pat(mem_req.id, mem_req.addr);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : chk1

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  // standby comes through a synchroniser, so allow a bounded wait
  task automatic wait_standby();
    int n;
    n = 0;
    while (standby !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk1(standby, 1'b1);
  endtask : wait_standby

  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic a;
    m.write_byte(d, a);
    chk1(a, exp_ack);
  endtask : send

  // dummy write that loads the address counter
  task automatic set_addr(input logic [3:0] ty, input logic [15:0] a);
    m.start();
    send({ty, sel, 1'b0}, 1'b1);
    send(a[15:8], 1'b1);
    send(a[7:0], 1'b1);
  endtask : set_addr

  // read n bytes from the current counter, expected to start at a
  task automatic read_run(input logic [3:0] ty, input logic id, input logic [15:0] a,
                          input int n);
    logic [7:0] d;
    logic       line;
    m.start();
    send({ty, sel, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.read_byte(i < n - 1, d, line);
      chk8(d, pat(id, a));
      a = id ? {a[15:7], a[6:0] + 7'h01} : a + 16'h0001;
    end
    chk1(line, 1'b1);
    m.stop();
    wait_standby();
  endtask : read_run

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic sc_wrap_seq();
    set_addr(TYPE_ARRAY, 16'hFFFE);
    read_run(TYPE_ARRAY, 1'b0, 16'hFFFE, 4);
    read_run(TYPE_ARRAY, 1'b0, 16'h0002, 1);
  endtask : sc_wrap_seq

  task automatic sc_last_loc();
    set_addr(TYPE_ARRAY, 16'hFFFF);
    read_run(TYPE_ARRAY, 1'b0, 16'hFFFF, 1);
    read_run(TYPE_ARRAY, 1'b0, 16'h0000, 2);
  endtask : sc_last_loc

  // upper address bits are junk and must be ignored
  task automatic sc_id_page();
    set_addr(TYPE_IDPAGE, 16'hF9E4);
    read_run(TYPE_IDPAGE, 1'b1, 16'h0064, 3);
  endtask : sc_id_page

  // wrong strap bit or wrong type code: no acknowledge
  task automatic sc_reject();
    for (int b = 0; b < 3; b++) begin
      m.start();
      send({TYPE_ARRAY, sel ^ (3'b001 << b), 1'b1}, 1'b0);
    end
    m.start();
    send({4'hC, sel, 1'b1}, 1'b0);
    m.stop();
    wait_standby();
  endtask : sc_reject

  // lock query answered by ack or nack, then start and stop abandon it
  task automatic sc_lock();
    for (int lk = 0; lk < 2; lk++) begin
      id_locked = lk[0];
      m.start();
      send({TYPE_IDPAGE, sel, 1'b0}, 1'b1);
      send(8'h04, 1'b1);
      send(8'h00, 1'b1);
      send(8'h02, ~lk[0]);
      m.start();
      tick(4);
      chk1(standby, 1'b0);
      m.stop();
      wait_standby();
    end
    id_locked = 1'b0;
  endtask : sc_lock

  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // about 300 us of bus traffic expected; cut a hang well beyond that
  initial begin
    #(2_000_000);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    num_errors   = 0;
    total_checks = 0;
    sys_rst      = 1'b1;
    id_locked    = 1'b0;
    sel          = 3'b101;
    tick(5);
    sys_rst = 1'b0;
    tick(2);
    chk1(standby, 1'b1);
    chk1(sda_oe, 1'b0);
    chk1(mem_rd, 1'b0);
    read_run(TYPE_ARRAY, 1'b0, ADDR_RST, 2);
    sc_wrap_seq();
    sc_last_loc();
    sc_id_page();
    sc_reject();
    sc_lock();
    finish_test();
  end

endmodule : eeprom_two_wire_read_path_tb
